/* File: sabi_top.sv */
// pin-level conversion control and result read of the sampling converter
`timescale 1ns/1ps
`default_nettype none
module sabi_top #(
  parameter int unsigned CONV_CYCLES = sabi_pkg::CONV_CYC
) (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic                              convert_request_n,
  input  wire logic                              chip_select_n,
  input  wire logic                              output_drive_enable_n,
  input  wire logic                              done_flag_drive_enable_n,
  input  wire logic                              range_offset_input,
  input  wire logic [sabi_pkg::RESULT_WIDTH-1:0] analog_code,
  output var  logic                              done_flag,
  output var  logic                              done_flag_oe_n,
  output var  logic [sabi_pkg::RESULT_WIDTH-1:0] result_bits,
  output var  logic                              result_bits_oe_n
);
  // whole register image of the block and its next value
  sabi_pkg::sabi_regs_t           r;
  sabi_pkg::sabi_regs_t           next_r;

  // pin levels after the two synchroniser flops
  logic                           req_n_s;
  logic                           oe_n_s;
  logic                           cs_n_s;
  logic                           done_flag_drive_enable_n_n_s;
  logic                           bipolar_s;

  // one-cycle strobes on the synchronised edges
  logic                           req_fall;
  logic                           oe_fall;

  // counter reload values for the two timed phases
  logic [sabi_pkg::CNT_WIDTH-1:0] aperture_load;
  logic [sabi_pkg::CNT_WIDTH-1:0] convert_load;

  // cycles left after the sample so that the whole conversion takes CONV_CYCLES
  localparam int unsigned CONVERT_SPAN = CONV_CYCLES - sabi_pkg::APERTURE_CYC - 1;

  // synchroniser contents in reset: every strobe idles high, the range input low
  localparam sabi_pkg::sabi_sync_t SYNC_RESET = '{
    req_n:   2'h3,
    oe_n:    2'h3,
    cs_n:    2'h3,
    done_flag_drive_enable_n_n: 2'h3,
    bipolar: 2'h0
  };

  // whole register image in reset: flag high, both drivers off
  localparam sabi_pkg::sabi_regs_t REGS_RESET = '{
    sync:        SYNC_RESET,
    req_n_d:     1'b1,
    oe_n_d:      1'b1,
    state:       sabi_pkg::SABI_IDLE,
    count:       sabi_pkg::CNT_ZERO,
    sample:      sabi_pkg::RESULT_RESET,
    result:      sabi_pkg::RESULT_RESET,
    data_on:     1'b0,
    done_flag:   1'b1,
    done_oe_n:   1'b1,
    result_bits: sabi_pkg::RESULT_RESET,
    result_oe_n: 1'b1
  };

  // code the unsigned sample; bipolar flips the msb to two's complement
  function automatic logic [sabi_pkg::RESULT_WIDTH-1:0] sabi_code(
    input logic [sabi_pkg::RESULT_WIDTH-1:0] raw,
    input logic                              bipolar
  );
    sabi_code = raw;
    if (bipolar) begin
      sabi_code[sabi_pkg::RESULT_WIDTH-1] = ~raw[sabi_pkg::RESULT_WIDTH-1];
    end
  endfunction

  // one step of a two-flop synchroniser
  function automatic logic [1:0] sabi_shift(
    input logic [1:0] pair,
    input logic       pin
  );
    sabi_shift = {pair[0], pin};
  endfunction

  // one step of the down counter
  function automatic logic [sabi_pkg::CNT_WIDTH-1:0] sabi_dec(
    input logic [sabi_pkg::CNT_WIDTH-1:0] cnt
  );
    sabi_dec = cnt - sabi_pkg::CNT_ONE;
  endfunction

  // data drive: opens on an enable fall with select low, closes when either rises
  function automatic logic sabi_drive(
    input logic on,
    input logic oe_n_lvl,
    input logic cs_n_lvl,
    input logic oe_edge
  );
    // a level low enable alone never reopens the drive; it needs a fresh fall
    if (oe_n_lvl | cs_n_lvl) begin
      sabi_drive = 1'b0;
    end else if (oe_edge) begin
      sabi_drive = 1'b1;
    end else begin
      sabi_drive = on;
    end
  endfunction

  // idle: a request fall starts the aperture wait and drops the flag
  function automatic sabi_pkg::sabi_regs_t sabi_idle_step(
    input sabi_pkg::sabi_regs_t           cur,
    input logic                           start,
    input logic [sabi_pkg::CNT_WIDTH-1:0] load
  );
    // falls during a conversion never reach this step
    sabi_idle_step = cur;
    if (start) begin // RL7
      sabi_idle_step.state     = sabi_pkg::SABI_APERTURE;
      sabi_idle_step.count     = load;
      sabi_idle_step.done_flag = 1'b0; // RL1
    end
  endfunction

  // aperture: wait the sampling delay, then hold the input code
  function automatic sabi_pkg::sabi_regs_t sabi_aperture_step(
    input sabi_pkg::sabi_regs_t              cur,
    input logic [sabi_pkg::RESULT_WIDTH-1:0] code,
    input logic [sabi_pkg::CNT_WIDTH-1:0]    load
  );
    sabi_aperture_step = cur;
    if (cur.count == sabi_pkg::CNT_ONE) begin
      // input may change freely from here on
      sabi_aperture_step.sample = code; // RL7
      sabi_aperture_step.state  = sabi_pkg::SABI_CONVERT;
      sabi_aperture_step.count  = load;
    end else begin
      sabi_aperture_step.count = sabi_dec(cur.count);
    end
  endfunction

  // convert: count out the conversion time, then publish the word
  function automatic sabi_pkg::sabi_regs_t sabi_convert_step(
    input sabi_pkg::sabi_regs_t cur,
    input logic                 bipolar
  );
    sabi_convert_step = cur;
    if (cur.count == sabi_pkg::CNT_ZERO) begin
      // coding follows the range input as it stands at completion
      sabi_convert_step.result    = sabi_code(cur.sample, bipolar); // RL8 RL13
      sabi_convert_step.done_flag = 1'b1; // RL1 RL12
      sabi_convert_step.state     = sabi_pkg::SABI_IDLE;
    end else begin
      sabi_convert_step.count = sabi_dec(cur.count);
    end
  endfunction

  assign req_n_s   = r.sync.req_n[1];
  assign oe_n_s    = r.sync.oe_n[1];
  assign cs_n_s    = r.sync.cs_n[1];
  assign done_flag_drive_enable_n_n_s = r.sync.done_flag_drive_enable_n_n[1];
  assign bipolar_s = r.sync.bipolar[1];

  // edge strobes against the delayed synchronised levels
  assign req_fall  = r.req_n_d & ~req_n_s;
  assign oe_fall   = r.oe_n_d & ~oe_n_s;

  // sampling waits the aperture delay; the rest of the conversion time follows
  assign aperture_load = sabi_pkg::CNT_WIDTH'(sabi_pkg::APERTURE_CYC);
  assign convert_load  = sabi_pkg::CNT_WIDTH'(CONVERT_SPAN);

  always_comb begin
    next_r = r;

    // synchronisers on every control pin from outside the clock domain; analog_code is sampled unsynchronised
    next_r.sync.req_n   = sabi_shift(r.sync.req_n, convert_request_n);
    next_r.sync.oe_n    = sabi_shift(r.sync.oe_n, output_drive_enable_n);
    next_r.sync.cs_n    = sabi_shift(r.sync.cs_n, chip_select_n);
    next_r.sync.done_flag_drive_enable_n_n = sabi_shift(r.sync.done_flag_drive_enable_n_n, done_flag_drive_enable_n);
    next_r.sync.bipolar = sabi_shift(r.sync.bipolar, range_offset_input);
    // delayed levels for the edge strobes
    next_r.req_n_d = req_n_s;
    next_r.oe_n_d  = oe_n_s;

    // conversion sequence
    case (r.state)
      sabi_pkg::SABI_IDLE: begin
        next_r = sabi_idle_step(next_r, req_fall, aperture_load);
      end
      sabi_pkg::SABI_APERTURE: begin
        next_r = sabi_aperture_step(next_r, analog_code, convert_load);
      end
      sabi_pkg::SABI_CONVERT: begin
        next_r = sabi_convert_step(next_r, bipolar_s);
      end
      default: begin
        next_r.state = sabi_pkg::SABI_IDLE;
      end
    endcase

    // pin drivers, registered so the outputs come from flops
    next_r.data_on     = sabi_drive(r.data_on, oe_n_s, cs_n_s, oe_fall); // RL4 RL9
    next_r.result_bits = next_r.result; // RL3
    next_r.result_oe_n = ~next_r.data_on; // RL4
    next_r.done_oe_n   = done_flag_drive_enable_n_n_s; // RL2
  end

  // asynchronous reset loads constants only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // every output comes straight from its register
  assign done_flag        = r.done_flag;
  assign done_flag_oe_n   = r.done_oe_n;
  assign result_bits      = r.result_bits;
  assign result_bits_oe_n = r.result_oe_n;
endmodule
`default_nettype wire

/* File: sabi_pkg.sv */
// constants and types of the sampling converter bus interface
// Summary of operation
// [RL1] the done flag drops when a conversion begins and rises when it completes.
// [RL2] the done flag pin is driven only while its active-low drive enable is low.
// [RL3] the result is one parallel word of 14 active-high bits read in one access.
// [RL4] result bits are enabled by a falling edge of output enable and float otherwise.
// [RL5] the host selects the device for a read by holding chip select low.
// [RL6] the host requests a conversion by driving the convert request low.
// [RL7] the falling edge of the convert request starts sampling after a short delay.
// [RL8] range offset at analog ground codes straight binary, at the reference two's complement.
// [RL9] the host lowers chip select the enable delay before output enable; data drives only when both are low.
// [RL10] after output enable rises the host waits the conversion delay before the next request.
// [RL11] the host does not hold the convert request low for continuous conversion.
// [RL12] each conversion completes within the maximum conversion time.
// [RL13] the last result stays unchanged in the output register until the next one completes.
package sabi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned RESULT_WIDTH    = 14;
  localparam int unsigned APERTURE_MIN_NS = 5;
  localparam int unsigned CONV_TIME_NS    = 6300;
  localparam int unsigned APERTURE_CYC    =
    (APERTURE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_WIDTH       = 9;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE  = 9'h001;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 14'h0000;

  typedef enum logic [1:0] {
    SABI_IDLE,
    SABI_APERTURE,
    SABI_CONVERT
  } sabi_state_t;

  typedef struct packed {
    logic [1:0] req_n;
    logic [1:0] oe_n;
    logic [1:0] cs_n;
    logic [1:0] done_flag_drive_enable_n_n;
    logic [1:0] bipolar;
  } sabi_sync_t;

  typedef struct packed {
    sabi_sync_t                sync;
    logic                      req_n_d;
    logic                      oe_n_d;
    sabi_state_t               state;
    logic [CNT_WIDTH-1:0]      count;
    logic [RESULT_WIDTH-1:0]   sample;
    logic [RESULT_WIDTH-1:0]   result;
    logic                      data_on;
    logic                      done_flag;
    logic                      done_oe_n;
    logic [RESULT_WIDTH-1:0]   result_bits;
    logic                      result_oe_n;
  } sabi_regs_t;
endpackage

/* File: sabi_checker.sv */
// assertions on the converter pins
`timescale 1ns/1ps
`default_nettype none
module sabi_checker #(
  parameter int unsigned CONV_CYCLES = sabi_pkg::CONV_CYC
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        convert_request_n,
  input wire logic        chip_select_n,
  input wire logic        output_drive_enable_n,
  input wire logic        done_flag_drive_enable_n,
  input wire logic        range_offset_input,
  input wire logic        done_flag,
  input wire logic        done_flag_oe_n,
  input wire logic        result_bits_oe_n,
  input wire logic [13:0] analog_code,
  input wire logic [13:0] result_bits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start; $fell(convert_request_n) && done_flag; endsequence
  a_busy_start: assert property (s_start |-> ##3 !done_flag) else $error("start");
  a_conv_len: assert property ($fell(done_flag) |-> ##CONV_CYCLES $rose(done_flag))
    else $error("len");
  a_flag_drive: assert property ($changed(done_flag_drive_enable_n) |->
    ##3 done_flag_oe_n == $past(done_flag_drive_enable_n, 3)) else $error("flag oe");
  a_read_open: assert property ($fell(output_drive_enable_n) && !chip_select_n
    |-> ##3 !result_bits_oe_n) else $error("open");
  a_read_nosel: assert property (chip_select_n |-> ##3 result_bits_oe_n) else $error("cs");
  a_read_close: assert property (output_drive_enable_n |-> ##3 result_bits_oe_n)
    else $error("close");
  a_result_hold: assert property (!$rose(done_flag) |-> $stable(result_bits))
    else $error("hold");
  a_result_code: assert property ($rose(done_flag) |->
    result_bits == (analog_code ^ {range_offset_input, 13'h0000})) else $error("code");
endmodule
bind sabi_top sabi_checker #(.CONV_CYCLES(CONV_CYCLES)) sabi_checker_i (.*);
`default_nettype wire

/* File: sabi_host.sv */
// host model driving the converter strobes
`timescale 1ns/1ps
`default_nettype none
module sabi_host (
  input  wire logic        ref_clk,
  input  wire logic [13:0] result_bits,
  input  wire logic        result_bits_oe_n,
  output var  logic        convert_request_n,
  output var  logic        chip_select_n,
  output var  logic        output_drive_enable_n
);
  initial {convert_request_n, chip_select_n, output_drive_enable_n} = 3'h7;
  task automatic convert();
    @(negedge ref_clk) convert_request_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    convert_request_n = 1'b1;
  endtask
  task automatic rd(input logic cs, output logic [13:0] d, output logic oe);
    @(negedge ref_clk) chip_select_n = cs;
    @(negedge ref_clk) output_drive_enable_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    d = result_bits;
    oe = result_bits_oe_n;
    output_drive_enable_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (16) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: sabi_top_tb.sv */
// self-checking bench of the converter interface
`timescale 1ns/1ps
`default_nettype none
module sabi_top_tb;
  logic ref_clk = 1'b0, reset_n = 1'b0, done_flag_drive_enable_n = 1'b0, range_offset_input = 1'b0;
  logic convert_request_n, chip_select_n, output_drive_enable_n, done_flag, done_flag_oe_n;
  logic result_bits_oe_n, g_oe;
  logic [13:0] analog_code = 14'h0000, result_bits, g, e;
  logic [31:0] s = 32'h2370;
  int n_fail = 0, compares = 0, cyc = 0, w;
  always #12.5 ref_clk = ~ref_clk;
  sabi_top #(.CONV_CYCLES(8)) sabi_top_i (.*);
  sabi_host sabi_host_i (.*);
  task automatic chk(input logic [13:0] v, input logic [13:0] x);
    compares++;
    if (v !== x) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, v, x); end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction
  // straight binary, or msb inverted for two's complement of the same input
  function automatic logic [13:0] expect_code(input logic [13:0] raw, input logic bip);
    expect_code = bip ? {~raw[13], raw[12:0]} : raw;
  endfunction
  task automatic wrap_up();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 3000) begin n_fail++; wrap_up(); end
  initial begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = xorshift(s);
      analog_code = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : s[13:0];
      range_offset_input = s[20];
      done_flag_drive_enable_n = 1'b0;
      e = expect_code(analog_code, range_offset_input);
      sabi_host_i.convert();
      chk(done_flag, 1'b0);
      chk(done_flag_oe_n, 1'b0);
      sabi_host_i.convert();
      for (w = 0; w < 20 && done_flag !== 1'b1; w++) @(negedge ref_clk);
      repeat (6) @(negedge ref_clk);
      chk(done_flag, 1'b1);
      sabi_host_i.rd(1'b0, g, g_oe);
      chk(g_oe, 1'b0);
      chk(g, e);
      sabi_host_i.rd(1'b0, g, g_oe);
      chk(g, e);
      sabi_host_i.rd(1'b1, g, g_oe);
      chk(g_oe, 1'b1);
      done_flag_drive_enable_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(done_flag_oe_n, 1'b1);
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
